// File: src/ebt_pkg.sv
// Purpose: Shared constants and types of the expansion bus cycle timer
// Assumes: Phase lengths are given as programmed codes; a code of n lasts n+1 cycles, n+2 for host-port recovery
// Notes:   Mode codes match the i_mode port encoding
package ebt_pkg;
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 8;
  localparam int SHORT_W = 2;
  localparam int LONG_W  = 4;
  localparam int CNT_W   = 5;

  // Phase code n gives n + PHASE_BASE cycles
  localparam logic [CNT_W-1:0] PHASE_BASE   = 5'h01;
  localparam logic [CNT_W-1:0] CNT_LAST     = 5'h01;
  // Address stays on the lines this long after the latch strobe falls
  localparam logic [CNT_W-1:0] ALE_HOLD_CYC = 5'h01;
  // Host-port recovery is one cycle longer than the strobe modes
  localparam logic [CNT_W-1:0] HOST_RECOV_X = 5'h01;

  typedef enum logic [1:0] {
    EBT_MODE_MUX     = 2'h0,
    EBT_MODE_SIMPLEX = 2'h1,
    EBT_MODE_HOST    = 2'h2
  } ebt_mode_e;

  typedef enum logic [2:0] {
    EBT_IDLE,
    EBT_ADDR,
    EBT_AHOLD,
    EBT_SETUP,
    EBT_STROBE,
    EBT_HOLD,
    EBT_RECOV
  } ebt_state_e;
endpackage

// File: src/ebt_cycle.sv
// Purpose: Sequences one expansion bus access through its five timed phases
// Assumes: One 100 MHz clock, synchronous active-high reset, pins sampled by 2 flops
// Notes:   Settings and request fields are captured when a request is taken
`timescale 1ns/1ps
module ebt_cycle (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst,
  input  wire logic [1:0]                 i_mode,
  input  wire logic [ebt_pkg::SHORT_W-1:0] i_address_phase_len,
  input  wire logic [ebt_pkg::SHORT_W-1:0] i_setup_phase_len,
  input  wire logic [ebt_pkg::LONG_W-1:0]  i_strobe_phase_len,
  input  wire logic [ebt_pkg::SHORT_W-1:0] i_hold_phase_len,
  input  wire logic [ebt_pkg::LONG_W-1:0]  i_recovery_phase_len,
  input  wire logic                       i_req,
  input  wire logic                       i_wr,
  input  wire logic [ebt_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [ebt_pkg::DATA_W-1:0]  i_wdata,
  output logic                            o_ready,
  output logic                            o_done,
  output logic [ebt_pkg::DATA_W-1:0]       o_rdata,
  output logic [ebt_pkg::ADDR_W-1:0]       o_addr,
  output logic                            o_addr_oe,
  output logic                            o_address_latch_strobe,
  output logic                            o_cs_n,
  output logic                            o_bus_rnw,
  output logic                            o_bus_data_strobe_n,
  output logic                            o_host_data_strobe_n,
  output logic [ebt_pkg::DATA_W-1:0]       o_data,
  output logic                            o_data_oe,
  input  wire logic [ebt_pkg::DATA_W-1:0]  i_data,
  input  wire logic                       i_host_port_wait
);
  localparam int CW = ebt_pkg::CNT_W;

  function automatic logic [CW-1:0] plen(input logic [ebt_pkg::LONG_W-1:0] code);
    plen = {1'b0, code} + ebt_pkg::PHASE_BASE;
  endfunction

  ebt_pkg::ebt_state_e state_q, state_d;
  ebt_pkg::ebt_mode_e  mode_q, mode_d;
  logic [CW-1:0]                  cnt_q, cnt_d;
  logic                           wait_seen_q, wait_seen_d;
  logic                           wr_q, wr_d;
  logic [ebt_pkg::ADDR_W-1:0]      addr_q, addr_d;
  logic [ebt_pkg::DATA_W-1:0]      wdata_q, wdata_d, rdata_d;
  logic [ebt_pkg::SHORT_W-1:0]     setup_q, setup_d, hold_q, hold_d;
  logic [ebt_pkg::LONG_W-1:0]      strobe_q, strobe_d, recov_q, recov_d;
  logic                           done_d, addr_oe_d, ale_d, cs_n_d;
  logic                           ds_n_d, hds_n_d, data_oe_d, rnw_d;
  logic                           wait_m, wait_s;
  logic [ebt_pkg::DATA_W-1:0]      din_m, din_s;
  logic                           host, stall, waitable, active;

  // Pin inputs come from another domain
  always_ff @(posedge i_sys_clk) begin
    wait_m <= i_host_port_wait;
    wait_s <= wait_m;
    din_m  <= i_data;
    din_s  <= din_m;
  end

  assign o_ready  = (state_q == ebt_pkg::EBT_IDLE);
  assign host     = (mode_q == ebt_pkg::EBT_MODE_HOST);
  assign waitable = (state_q == ebt_pkg::EBT_ADDR) || (state_q == ebt_pkg::EBT_STROBE);
  // A wait seen last cycle still stalls, giving one cycle after release
  assign stall    = host && waitable && (wait_s || wait_seen_q);

  always_comb begin
    state_d     = state_q;
    cnt_d       = (cnt_q > ebt_pkg::CNT_LAST) ? cnt_q - ebt_pkg::CNT_LAST : cnt_q;
    wait_seen_d = host && waitable && wait_s;
    mode_d      = mode_q;
    wr_d        = wr_q;
    addr_d      = addr_q;
    wdata_d     = wdata_q;
    setup_d     = setup_q;
    strobe_d    = strobe_q;
    hold_d      = hold_q;
    recov_d     = recov_q;
    rdata_d     = o_rdata;
    done_d      = 1'b0;
    unique case (state_q)
      ebt_pkg::EBT_IDLE: begin
        if (i_req) begin
          state_d  = ebt_pkg::EBT_ADDR;
          cnt_d    = plen({2'h0, i_address_phase_len});
          mode_d   = ebt_pkg::ebt_mode_e'(i_mode);
          wr_d     = i_wr;
          addr_d   = i_addr;
          wdata_d  = i_wdata;
          setup_d  = i_setup_phase_len;
          strobe_d = i_strobe_phase_len;
          hold_d   = i_hold_phase_len;
          recov_d  = i_recovery_phase_len;
        end
      end
      ebt_pkg::EBT_ADDR: begin
        if (cnt_q == ebt_pkg::CNT_LAST && !stall) begin
          if (mode_q == ebt_pkg::EBT_MODE_MUX) begin
            state_d = ebt_pkg::EBT_AHOLD;
            cnt_d   = ebt_pkg::ALE_HOLD_CYC;
          end else begin
            state_d = ebt_pkg::EBT_SETUP;
            cnt_d   = plen({2'h0, setup_q});
          end
        end
      end
      ebt_pkg::EBT_AHOLD: begin
        if (cnt_q == ebt_pkg::CNT_LAST) begin
          state_d = ebt_pkg::EBT_SETUP;
          cnt_d   = plen({2'h0, setup_q});
        end
      end
      ebt_pkg::EBT_SETUP: begin
        if (cnt_q == ebt_pkg::CNT_LAST) begin
          state_d = ebt_pkg::EBT_STROBE;
          cnt_d   = plen(strobe_q);
        end
      end
      ebt_pkg::EBT_STROBE: begin
        if (cnt_q == ebt_pkg::CNT_LAST && !stall) begin
          state_d = ebt_pkg::EBT_HOLD;
          cnt_d   = plen({2'h0, hold_q});
          if (!wr_q) begin
            rdata_d = din_s;
          end
        end
      end
      ebt_pkg::EBT_HOLD: begin
        if (cnt_q == ebt_pkg::CNT_LAST) begin
          state_d = ebt_pkg::EBT_RECOV;
          cnt_d   = plen(recov_q) + (host ? ebt_pkg::HOST_RECOV_X : '0);
        end
      end
      ebt_pkg::EBT_RECOV: begin
        if (cnt_q == ebt_pkg::CNT_LAST) begin
          state_d = ebt_pkg::EBT_IDLE;
          done_d  = 1'b1;
        end
      end
    endcase
  end

  // Pins follow the next state so they change on the same edge as the phase
  always_comb begin
    active    = (state_d == ebt_pkg::EBT_SETUP) || (state_d == ebt_pkg::EBT_STROBE)
                || (state_d == ebt_pkg::EBT_HOLD);
    ale_d     = (mode_d == ebt_pkg::EBT_MODE_MUX) && (state_d == ebt_pkg::EBT_ADDR);
    addr_oe_d = (state_d == ebt_pkg::EBT_ADDR) || (state_d == ebt_pkg::EBT_AHOLD)
                || (active && mode_d != ebt_pkg::EBT_MODE_MUX);
    cs_n_d    = !(active || (mode_d == ebt_pkg::EBT_MODE_HOST
                && state_d == ebt_pkg::EBT_ADDR));
    ds_n_d    = !(state_d == ebt_pkg::EBT_STROBE && mode_d != ebt_pkg::EBT_MODE_HOST);
    hds_n_d   = !(state_d == ebt_pkg::EBT_STROBE && mode_d == ebt_pkg::EBT_MODE_HOST);
    // Host writes keep data through recovery so it outlasts the strobe by three or more
    data_oe_d = wr_d && (active || (mode_d == ebt_pkg::EBT_MODE_HOST
                && state_d == ebt_pkg::EBT_RECOV));
    rnw_d     = !(wr_d && state_d != ebt_pkg::EBT_IDLE);
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q                <= ebt_pkg::EBT_IDLE;
      mode_q                 <= ebt_pkg::EBT_MODE_MUX;
      cnt_q                  <= '0;
      wait_seen_q            <= 1'b0;
      wr_q                   <= 1'b0;
      addr_q                 <= '0;
      wdata_q                <= '0;
      setup_q                <= '0;
      strobe_q               <= '0;
      hold_q                 <= '0;
      recov_q                <= '0;
      o_rdata                <= '0;
      o_done                 <= 1'b0;
      o_addr                 <= '0;
      o_addr_oe              <= 1'b0;
      o_address_latch_strobe <= 1'b0;
      o_cs_n                 <= 1'b1;
      o_bus_rnw              <= 1'b1;
      o_bus_data_strobe_n    <= 1'b1;
      o_host_data_strobe_n   <= 1'b1;
      o_data                 <= '0;
      o_data_oe              <= 1'b0;
    end else begin
      state_q                <= state_d;
      mode_q                 <= mode_d;
      cnt_q                  <= cnt_d;
      wait_seen_q            <= wait_seen_d;
      wr_q                   <= wr_d;
      addr_q                 <= addr_d;
      wdata_q                <= wdata_d;
      setup_q                <= setup_d;
      strobe_q               <= strobe_d;
      hold_q                 <= hold_d;
      recov_q                <= recov_d;
      o_rdata                <= rdata_d;
      o_done                 <= done_d;
      o_addr                 <= addr_d;
      o_addr_oe              <= addr_oe_d;
      o_address_latch_strobe <= ale_d;
      o_cs_n                 <= cs_n_d;
      o_bus_rnw              <= rnw_d;
      o_bus_data_strobe_n    <= ds_n_d;
      o_host_data_strobe_n   <= hds_n_d;
      o_data                 <= wdata_d;
      o_data_oe              <= data_oe_d;
    end
  end

  // Checking helpers: cycles spent in the current phase
  logic [CW-1:0] run_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || state_q != state_d) begin
      run_q <= ebt_pkg::CNT_LAST;
    end else if (run_q != '1) begin
      run_q <= run_q + ebt_pkg::CNT_LAST;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_leave(ebt_pkg::ebt_state_e st);
    state_q == st && state_d != st;
  endsequence

  property p_ale_len;
    s_leave(ebt_pkg::EBT_ADDR) ##0 (mode_q == ebt_pkg::EBT_MODE_MUX)
      |-> run_q <= 5'h04 && o_address_latch_strobe;
  endproperty
  a_ale_len: assert property (p_ale_len) else $error("latch strobe length wrong");

  property p_addr_after_ale;
    $fell(o_address_latch_strobe) |-> o_addr_oe && $stable(o_addr) ##1 !o_addr_oe && !o_cs_n;
  endproperty
  a_addr_after_ale: assert property (p_addr_after_ale) else $error("address hold after latch");

  property p_setup_len;
    s_leave(ebt_pkg::EBT_SETUP) |-> run_q == plen({2'h0, setup_q});
  endproperty
  a_setup_len: assert property (p_setup_len) else $error("setup phase length wrong");

  property p_strobe_len;
    s_leave(ebt_pkg::EBT_STROBE) ##0 !host |-> run_q == plen(strobe_q);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe phase length wrong");

  property p_hold_keep;
    state_q == ebt_pkg::EBT_HOLD |-> !o_cs_n && o_bus_data_strobe_n
      && o_host_data_strobe_n && (o_data_oe == wr_q);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("hold phase lost select or data");

  property p_recov_len;
    s_leave(ebt_pkg::EBT_RECOV) |-> run_q == plen(recov_q) + (host ? 5'h01 : 5'h00);
  endproperty
  a_recov_len: assert property (p_recov_len) else $error("recovery length wrong");

  property p_simplex_no_ale;
    mode_q == ebt_pkg::EBT_MODE_SIMPLEX |-> !o_address_latch_strobe;
  endproperty
  a_simplex_no_ale: assert property (p_simplex_no_ale) else $error("latch strobe in simplex");

  property p_wait_freeze;
    host && waitable && wait_s |=> $stable(state_q) ##1 $stable(state_q);
  endproperty
  a_wait_freeze: assert property (p_wait_freeze) else $error("phase left during wait");

  property p_host_cs_addr;
    host && state_q != ebt_pkg::EBT_IDLE && state_q != ebt_pkg::EBT_RECOV
      |-> o_cs_n == !o_addr_oe;
  endproperty
  a_host_cs_addr: assert property (p_host_cs_addr) else $error("host address and select apart");

  property p_order;
    s_leave(ebt_pkg::EBT_STROBE) |=> state_q == ebt_pkg::EBT_HOLD ##[1:16]
      state_q == ebt_pkg::EBT_RECOV;
  endproperty
  a_order: assert property (p_order) else $error("phase order broken");
endmodule

// File: bench/ebt_periph.sv
// Purpose: Peripheral or DSP host port on the far side of the bus
// Assumes: Read data is driven while the block selects it for a read
// Notes:   Wait is raised only when the bench asks for a stall
`timescale 1ns/1ps
module ebt_periph (
  input  wire logic       i_sys_clk,
  input  wire logic       i_cs_n,
  input  wire logic       i_hstb_n,
  input  wire logic       i_bus_rnw,
  input  wire logic [7:0] i_rd_val,
  input  wire logic [3:0] i_stall,
  output logic [7:0]      o_data,
  output logic            o_host_port_wait
);
  logic [7:0] pat_q;
  logic [3:0] left_q;
  logic       cs_n_q;
  logic       hstb_n_q;
  initial begin
    pat_q = 8'hA5;
    left_q = 4'h0;
    cs_n_q = 1'b1;
    hstb_n_q = 1'b1;
  end
  // Released lines show a moving pattern so stale data matches only when the pattern happens to equal the read value
  assign o_data = (!i_cs_n && i_bus_rnw) ? i_rd_val : pat_q;
  assign o_host_port_wait = left_q != 4'h0;
  always @(posedge i_sys_clk) begin
    pat_q <= pat_q + 8'h3B;
    cs_n_q <= i_cs_n;
    hstb_n_q <= i_hstb_n;
    // A stall starts once as the select falls and once as the host strobe falls
    if ((cs_n_q && !i_cs_n) || (hstb_n_q && !i_hstb_n)) left_q <= i_stall;
    else if (left_q != 4'h0) left_q <= left_q - 4'h1;
  end
endmodule

// File: bench/testbench.sv
// Purpose: Self-checking bench for the expansion bus cycle timer
// Assumes: Outputs settle within 1 ns of the rising clock edge
// Notes:   Read data is compared in host mode, or when setup and strobe outlast the input synchronizer
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, req, wr, ready, done, aoe, ale, cs_n, rnw, bstb_n, hstb_n, doe, wt;
  logic [1:0]  mode, ac, sc, hc;
  logic [3:0]  tc, rc, stall;
  logic [15:0] addr, oaddr;
  logic [7:0]  wd, rv, pin, rdata, odata;
  int          fail_count, samples_checked;

  ebt_cycle u_ebt_cycle (.i_sys_clk(clk), .i_rst(rst), .i_mode(mode),
    .i_address_phase_len(ac), .i_setup_phase_len(sc), .i_strobe_phase_len(tc),
    .i_hold_phase_len(hc), .i_recovery_phase_len(rc), .i_req(req), .i_wr(wr),
    .i_addr(addr), .i_wdata(wd), .o_ready(ready), .o_done(done), .o_rdata(rdata),
    .o_addr(oaddr), .o_addr_oe(aoe), .o_address_latch_strobe(ale), .o_cs_n(cs_n),
    .o_bus_rnw(rnw), .o_bus_data_strobe_n(bstb_n), .o_host_data_strobe_n(hstb_n),
    .o_data(odata), .o_data_oe(doe), .i_data(pin), .i_host_port_wait(wt));
  ebt_periph u_ebt_periph (.i_sys_clk(clk), .i_cs_n(cs_n), .i_hstb_n(hstb_n), .i_bus_rnw(rnw),
    .i_rd_val(rv), .i_stall(stall), .o_data(pin), .o_host_port_wait(wt));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // The far side raises wait one cycle into a phase; two synchroniser flops follow
  localparam int WAIT_SEEN = 3;

  // Phase length under a stall of k cycles: a last cycle that meets the seen wait
  // is held until the wait drops, and one cycle more
  function automatic int held(input int base, input int k);
    if (k != 0 && base > WAIT_SEEN && base < WAIT_SEEN + k + 2) begin
      return WAIT_SEEN + k + 2;
    end
    return base;
  endfunction

  // One access, taken back to back with the previous one
  task automatic go(input logic [1:0] m, input logic [1:0] a, input logic [1:0] s,
                    input logic [3:0] t, input logic [1:0] h, input logic [3:0] r,
                    input logic w, input logic [3:0] k);
    int n, na, no, nc, ns, ta, t_a, tc0, ts0, ts1, td0, td1, la, ls, lt, ld, lr;
    logic sb;
    {mode, ac, sc, tc, hc, rc, wr, stall} = {m, a, s, t, h, r, w, k};
    addr = 16'($urandom);
    wd = 8'($urandom);
    rv = 8'($urandom);
    req = 1'b1;
    check(ready, 1'b1);
    @(posedge clk);
    #1 req = 1'b0;
    // Each pass looks at the cycle that the last edge launched, the first one included
    while (!done) begin
      n++;
      if (n > 300) begin
        fail_count++;
        tally_and_finish();
      end
      sb = (m == 2'h2) ? hstb_n : bstb_n;
      na += ale;
      no += aoe;
      nc += !cs_n;
      ns += !sb;
      if (ale) ta = n;
      if (aoe && t_a == 0) t_a = n;
      if (!cs_n && tc0 == 0) tc0 = n;
      if (!sb && ts0 == 0) ts0 = n;
      if (!sb) ts1 = n + 1;
      if (doe && td0 == 0) td0 = n;
      if (doe) td1 = n + 1;
      check(m == 2'h2 ? bstb_n : hstb_n, 1'b1);
      if (aoe) check(oaddr, addr);
      if (!sb) check(doe, wr);
      if (!sb && wr) check(odata, wd);
      if (!cs_n) check(rnw, !wr);
      @(posedge clk);
      #1;
    end
    la = held(a + 1, k);
    ls = s + 1;
    lt = held(t + 1, k);
    ld = h + 1;
    lr = r + 1 + (m == 2'h2);
    check(ts0 > tc0, 1'b1);
    check(n, la + (m == 2'h0) + ls + lt + ld + lr);
    check(ns, lt);
    if (m == 2'h0) begin
      check(na, la);
      check(no, la + 1);
      check(tc0 - ta >= 2 && tc0 - ta <= 5, 1'b1);
    end
    if (m == 2'h1) begin
      check(na, 0);
      check(no, la + ls + lt + ld);
      check(tc0 - t_a, la);
    end
    if (m != 2'h2) check(nc, ls + lt + ld);
    if (m != 2'h2 && wr) begin
      check(ts0 - td0, ls);
      check(td1 - ts1, ld);
    end
    if (m == 2'h2) begin
      check(tc0, t_a);
      check(nc, no);
      check(ts0 - tc0, la + ls);
      if (k == 0) check(no >= 11 && no <= 45, 1'b1);
      if (k == 0) check(ns >= 4 && ns <= 5, 1'b1);
      if (wr) check(td1 - ts1, ld + lr);
      if (wr) check(td1 - ts1 >= 4 && td1 - ts1 <= 36, 1'b1);
    end
    if (!wr && (m == 2'h2 || s != 0 || t != 0)) check(rdata, rv);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    logic [1:0] m, a, s, h;
    logic [3:0] t, k;
    {rst, req, wr, mode, ac, sc, hc, tc, rc, stall, addr, wd, rv} = '0;
    rst = 1'b1;
    void'($urandom(32'h825E));
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    go(2'h0, 2'h0, 2'h0, 4'h0, 2'h0, 4'h0, 1'b1, 4'h0);
    go(2'h0, 2'h3, 2'h3, 4'hF, 2'h3, 4'hF, 1'b0, 4'h0);
    go(2'h1, 2'h3, 2'h0, 4'h0, 2'h3, 4'h0, 1'b1, 4'h0);
    go(2'h1, 2'h0, 2'h3, 4'hF, 2'h0, 4'hF, 1'b0, 4'h0);
    go(2'h2, 2'h2, 2'h2, 4'h3, 2'h2, 4'h0, 1'b1, 4'h0);
    go(2'h2, 2'h2, 2'h2, 4'h4, 2'h3, 4'hF, 1'b0, 4'h4);
    go(2'h2, 2'h3, 2'h2, 4'h3, 2'h2, 4'h0, 1'b1, 4'h1);
    for (int i = 0; i < 40; i++) begin
      m = 2'($urandom_range(2, 0));
      a = (m == 2'h2) ? 2'($urandom_range(3, 2)) : 2'($urandom);
      s = (m == 2'h2) ? 2'($urandom_range(3, 2)) : 2'($urandom);
      t = (m == 2'h2) ? 4'($urandom_range(4, 3)) : 4'($urandom);
      h = (m == 2'h2) ? 2'($urandom_range(3, 2)) : 2'($urandom);
      k = (m == 2'h2 && $urandom_range(1, 0) == 1) ? 4'($urandom_range(4, 1)) : 4'h0;
      go(m, a, s, t, h, 4'($urandom), 1'($urandom), k);
    end
    tally_and_finish();
  end
endmodule
